//--- core/cps_core_regs.sv
`timescale 1ns/100ps
module cps_core_regs #(
    parameter int STACK_DEPTH = 31
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    // Avalon-MM slave
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Datapath
    input wire cps_pkg::cps_alu_t alu,
    input wire cps_pkg::cps_evt_t evt,
    input wire logic [21:0] call_pc,
    input wire logic [7:0] work_reg,
    output logic [21:0] pc,
    output logic [7:0] status,
    // Data memory
    output cps_pkg::cps_mem_t mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ready
);
    import cps_pkg::*;

    typedef enum logic [1:0] {CPS_IDLE, CPS_MEM, CPS_DONE} cps_state_t;

    cps_state_t state_q;
    logic [21:0] pc_q;
    logic [12:0] latch_q;
    logic [4:0] sp_q;
    logic [21:0] stack_q [STACK_DEPTH+1];
    logic [7:0] status_q;
    logic [7:0] wshadow_q;
    logic [11:0] fsr_q [3];
    logic [31:0] rdata_q;
    logic [11:0] reg_idx;
    logic wr_ok;
    logic [1:0] ind_sel;
    logic is_ind;
    logic [1:0] ind_mode;
    logic [3:0] ind_code;
    logic [8:0] sum9;
    logic [4:0] nib;
    logic [7:0] res;

    // Register index from byte address; only byte lane 0 enables a write, upper lanes are ignored even for wide registers
    assign reg_idx = avs_address[13:2];
    assign wr_ok = avs_byteenable[0];

    // Map an address to indirect pointer 0 or 1 and mode (0 plain, 1 inc, 2 dec)
    function automatic logic [3:0] ind_decode(input logic [11:0] a);
        case (a)
            CPS_IND0: ind_decode = 4'h8;
            CPS_INC0: ind_decode = 4'h9;
            CPS_DEC0: ind_decode = 4'hA;
            CPS_IND1: ind_decode = 4'hC;
            CPS_INC1: ind_decode = 4'hD;
            CPS_DEC1: ind_decode = 4'hE;
            CPS_IND2: ind_decode = 4'h0 | 4'h0;
            default: ind_decode = 4'h0;
        endcase
    endfunction

    // Decoded pointer code, held in a net so its bits can be selected
    assign ind_code = ind_decode(reg_idx);

    // Indirect decode with pointer 2 handled explicitly
    always_comb begin
        is_ind = 1'b0;
        ind_sel = 2'd0;
        ind_mode = 2'd0;
        if (ind_code[3]) begin
            is_ind = 1'b1;
            ind_sel = {1'b0, ind_code[2]};
            ind_mode = ind_code[1:0];
        end else if (reg_idx == CPS_IND2 || reg_idx == CPS_INC2 || reg_idx == CPS_DEC2) begin
            is_ind = 1'b1;
            ind_sel = 2'd2;
            ind_mode = (reg_idx == CPS_INC2) ? 2'd1 : (reg_idx == CPS_DEC2) ? 2'd2 : 2'd0;
        end
    end

    // Bus handshake: direct registers answer in one cycle, indirect waits on memory
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= CPS_IDLE;
        end else begin
            case (state_q)
                CPS_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_q <= is_ind ? CPS_MEM : CPS_DONE;
                    end
                end
                CPS_MEM: begin
                    if (mem_ready) begin
                        state_q <= CPS_DONE;
                    end
                end
                CPS_DONE: state_q <= CPS_IDLE;
                default: state_q <= CPS_IDLE;
            endcase
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && (state_q != CPS_DONE);
    assign avs_readdata = rdata_q;
    wire take = (state_q == CPS_DONE) && (avs_read || avs_write);
    wire wr_take = take && avs_write && wr_ok;
    wire rd_take = take && avs_read;

    // Data memory request drives pointer address during indirect access
    always_comb begin
        mem_req.rd = (state_q == CPS_MEM) && avs_read && is_ind;
        mem_req.wr = (state_q == CPS_MEM) && avs_write && wr_ok && is_ind;
        mem_req.addr = fsr_q[ind_sel];
        mem_req.wdata = avs_writedata[7:0];
    end

    // Read data capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= CPS_UNMAPPED;
        end else if (state_q == CPS_MEM && mem_ready) begin
            rdata_q <= {24'h000000, mem_rdata};
        end else if (state_q == CPS_IDLE && avs_read) begin
            case (reg_idx)
                CPS_STATUS: rdata_q <= {24'h000000, 1'b0, status_q[6:0]};
                CPS_WSHADOW: rdata_q <= {24'h000000, wshadow_q};
                CPS_FSR0: rdata_q <= {20'h00000, fsr_q[0]};
                CPS_FSR1: rdata_q <= {20'h00000, fsr_q[1]};
                CPS_FSR2: rdata_q <= {20'h00000, fsr_q[2]};
                CPS_PCLOW: rdata_q <= {24'h000000, pc_q[7:0]};
                CPS_PCLATCH: rdata_q <= {19'h00000, latch_q};
                CPS_STACK_POINTER: rdata_q <= {27'h0000000, sp_q};
                CPS_STKTOP: rdata_q <= {8'h00, 3'b000, stack_q[sp_q][21:17],
                    stack_q[sp_q][15:8], stack_q[sp_q][7:0]};
                default: rdata_q <= CPS_UNMAPPED;
            endcase
        end
    end

    // File select pointers with post step after the access completes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                fsr_q[i] <= CPS_FSR_RST;
            end
        end else if (wr_take && reg_idx == CPS_FSR0) begin
            fsr_q[0] <= avs_writedata[11:0];
        end else if (wr_take && reg_idx == CPS_FSR1) begin
            fsr_q[1] <= avs_writedata[11:0];
        end else if (wr_take && reg_idx == CPS_FSR2) begin
            fsr_q[2] <= avs_writedata[11:0];
        end else if (take && is_ind && ind_mode == 2'd1) begin
            fsr_q[ind_sel] <= fsr_q[ind_sel] + 12'h001;
        end else if (take && is_ind && ind_mode == 2'd2) begin
            fsr_q[ind_sel] <= fsr_q[ind_sel] - 12'h001;
        end
    end

    // Working register shadow, no reset value
    always_ff @(posedge clk) begin
        if (wr_take && reg_idx == CPS_WSHADOW) begin
            wshadow_q <= avs_writedata[7:0];
        end else if (!(state_q == CPS_DONE)) begin
            wshadow_q <= wshadow_q;
        end
    end

    // Program counter and latch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_q <= CPS_PC_RST;
            latch_q <= CPS_LATCH_RST;
        end else begin
            if (rd_take && reg_idx == CPS_PCLOW) begin
                latch_q <= {pc_q[21:17], pc_q[15:8]};
            end else if (wr_take && reg_idx == CPS_PCLATCH) begin
                latch_q <= avs_writedata[12:0];
            end
            if (wr_take && reg_idx == CPS_PCLOW) begin
                pc_q <= {latch_q[12:8], 1'b0, latch_q[7:0], avs_writedata[7:0]};
            end else if (evt.ret) begin
                pc_q <= stack_q[sp_q];
            end
        end
    end

    // Stack memory and pointer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sp_q <= CPS_SP_RST;
        end else if (wr_take && reg_idx == CPS_STACK_POINTER) begin
            sp_q <= avs_writedata[4:0];
        end else if (evt.call) begin
            sp_q <= sp_q + 5'd1;
        end else if (evt.ret) begin
            sp_q <= sp_q - 5'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (evt.call) begin
            stack_q[sp_q + 5'd1] <= call_pc;
        end else if (wr_take && reg_idx == CPS_STKTOP) begin
            stack_q[sp_q] <= {avs_writedata[20:16], 1'b0,
                avs_writedata[15:8], avs_writedata[7:0]};
        end
    end

    // Flag calculation
    always_comb begin
        sum9 = 9'h000;
        nib = 5'h00;
        case (alu.op)
            CPS_OP_ADD: begin
                sum9 = {1'b0, alu.a} + {1'b0, alu.b};
                nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
            end
            CPS_OP_SUB: begin
                sum9 = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
                nib = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
            end
            default: begin
                sum9 = {1'b0, alu.src};
            end
        endcase
        res = sum9[7:0];
    end

    // Status flags; power-on sets both event flags, other resets keep state
    always_ff @(posedge clk) begin
        if (!por_n) begin
            status_q <= CPS_STATUS_POR;
        end else if (rst_n) begin
            if (evt.wdt_timeout) begin
                status_q[CPS_B_WDX] <= 1'b0;
            end else if (evt.wdt_clear || evt.sleep) begin
                status_q[CPS_B_WDX] <= 1'b1;
            end
            if (evt.sleep) begin
                status_q[CPS_B_SLP] <= 1'b0;
            end else if (evt.wdt_clear) begin
                status_q[CPS_B_SLP] <= 1'b1;
            end
            if (alu.op == CPS_OP_ADD || alu.op == CPS_OP_SUB) begin
                status_q[CPS_B_NEG] <= res[7];
                status_q[CPS_B_OV] <= (alu.a[7] == (alu.op == CPS_OP_SUB ? ~alu.b[7] : alu.b[7]))
                    && (res[7] != alu.a[7]);
                status_q[CPS_B_Z] <= (res == 8'h00);
                status_q[CPS_B_DC] <= nib[4];
                status_q[CPS_B_C] <= sum9[8];
            end else if (alu.op == CPS_OP_LOGIC) begin
                status_q[CPS_B_NEG] <= alu.src[7];
                status_q[CPS_B_Z] <= (alu.src == 8'h00);
            end else if (alu.op == CPS_OP_RRC) begin
                status_q[CPS_B_C] <= alu.src[0];
            end else if (alu.op == CPS_OP_RLC) begin
                status_q[CPS_B_C] <= alu.src[7];
            end else if (wr_take && reg_idx == CPS_STATUS) begin
                status_q[4:0] <= avs_writedata[4:0];
            end
        end
    end

    assign pc = pc_q;
    assign status = {1'b0, status_q[6:0]};
endmodule

//--- core/cps_pkg.sv
package cps_pkg;
    // Register word indices (printed values are indices, byte address is four times)
    localparam logic [11:0] CPS_STATUS = 12'hFD8;
    localparam logic [11:0] CPS_FSR2 = 12'hFD9;
    localparam logic [11:0] CPS_DEC2 = 12'hFDD;
    localparam logic [11:0] CPS_INC2 = 12'hFDE;
    localparam logic [11:0] CPS_IND2 = 12'hFDF;
    localparam logic [11:0] CPS_FSR1 = 12'hFE1;
    localparam logic [11:0] CPS_DEC1 = 12'hFE5;
    localparam logic [11:0] CPS_INC1 = 12'hFE6;
    localparam logic [11:0] CPS_IND1 = 12'hFE7;
    localparam logic [11:0] CPS_WSHADOW = 12'hFE8;
    localparam logic [11:0] CPS_FSR0 = 12'hFE9;
    localparam logic [11:0] CPS_DEC0 = 12'hFED;
    localparam logic [11:0] CPS_INC0 = 12'hFEE;
    localparam logic [11:0] CPS_IND0 = 12'hFEF;
    localparam logic [11:0] CPS_PCLOW = 12'hFF9;
    localparam logic [11:0] CPS_PCLATCH = 12'hFFA;
    localparam logic [11:0] CPS_STACK_POINTER = 12'hFFC;
    localparam logic [11:0] CPS_STKTOP = 12'hFFD;
    // Status bit positions
    localparam int CPS_B_WDX = 6;
    localparam int CPS_B_SLP = 5;
    localparam int CPS_B_NEG = 4;
    localparam int CPS_B_OV = 3;
    localparam int CPS_B_Z = 2;
    localparam int CPS_B_DC = 1;
    localparam int CPS_B_C = 0;
    // Reset values
    localparam logic [7:0] CPS_STATUS_POR = 8'h60;
    localparam logic [21:0] CPS_PC_RST = 22'h000000;
    localparam logic [12:0] CPS_LATCH_RST = 13'h0000;
    localparam logic [11:0] CPS_FSR_RST = 12'h000;
    localparam logic [31:0] CPS_UNMAPPED = 32'h00000000;
    localparam logic [4:0] CPS_SP_RST = 5'h00;
    // ALU operation classes from the datapath
    typedef enum logic [2:0] {
        CPS_OP_NONE, CPS_OP_LOGIC, CPS_OP_ADD, CPS_OP_SUB, CPS_OP_RRC, CPS_OP_RLC
    } cps_op_t;
    // Datapath flag update bundle
    typedef struct packed {
        cps_op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] src;
    } cps_alu_t;
    // Core events
    typedef struct packed {
        logic wdt_clear;
        logic sleep;
        logic wdt_timeout;
        logic ret;
        logic call;
    } cps_evt_t;
    // Data memory request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } cps_mem_t;
endpackage

//--- verification/cps_mem_model.sv
`timescale 1ns/100ps
// Data memory behind the indirect registers, answering after a set latency
module cps_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request side
    input wire cps_pkg::cps_mem_t req,
    output logic [7:0] rdata,
    output logic ready,
    // Bench controls
    input wire logic [3:0] lat,
    input wire logic ld,
    input wire logic [11:0] ld_a,
    input wire logic [7:0] ld_d
);
    import cps_pkg::*;
    logic [7:0] mem [4096];
    logic [3:0] cnt_q;
    // Count out the latency, answer once, show stale data inverted otherwise
    always_ff @(posedge clk) begin
        ready <= 1'b0;
        rdata <= ~rdata;
        if (!rst_n) begin
            cnt_q <= 4'h0;
            rdata <= 8'h00;
        end else if ((req.rd || req.wr) && !ready) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= lat) begin
                ready <= 1'b1;
                cnt_q <= 4'h0;
                rdata <= mem[req.addr];
                if (req.wr) mem[req.addr] <= req.wdata;
            end
        end else begin
            cnt_q <= 4'h0;
        end
        if (ld) mem[ld_a] <= ld_d;
    end
endmodule

//--- verification/cps_core_regs_sva.sv
`timescale 1ns/100ps
module cps_core_regs_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    // Bus
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_waitrequest,
    // Datapath
    input wire cps_pkg::cps_alu_t alu,
    input wire cps_pkg::cps_evt_t evt,
    input wire logic [7:0] status,
    // Memory
    input wire cps_pkg::cps_mem_t mem_req,
    input wire logic mem_ready
);
    import cps_pkg::*;
    logic [8:0] sum_w;
    logic [4:0] nib_w;
    logic add_w;
    logic ovf_w;
    // Reference results of an add
    assign sum_w = {1'b0, alu.a} + {1'b0, alu.b};
    assign nib_w = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
    assign add_w = alu.op == CPS_OP_ADD;
    assign ovf_w = (alu.a[7] == alu.b[7]) && (sum_w[7] != alu.a[7]);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_add_carry: assert property (add_w |=> status[CPS_B_C] == $past(sum_w[8]))
        else $error("carry flag wrong after add");
    chk_nibble_carry: assert property (add_w |=> status[CPS_B_DC] == $past(nib_w[4]))
        else $error("nibble carry wrong after add");
    chk_signed_wrap: assert property (add_w |=> status[CPS_B_OV] == $past(ovf_w))
        else $error("overflow flag wrong after add");
    chk_sign_zero: assert property (add_w |=> status[CPS_B_NEG] == $past(sum_w[7])
        && status[CPS_B_Z] == ($past(sum_w[7:0]) == 8'h00)) else $error("sign or zero wrong");
    chk_rotate_right: assert property (alu.op == CPS_OP_RRC |=> status[0] == $past(alu.src[0]))
        else $error("carry wrong after right rotate");
    chk_rotate_left: assert property (alu.op == CPS_OP_RLC |=> status[0] == $past(alu.src[7]))
        else $error("carry wrong after left rotate");
    chk_sleep_flags: assert property (evt.sleep |=> status[6:5] == 2'b10)
        else $error("flags wrong after sleep");
    chk_timeout_flag: assert property (evt.wdt_timeout |=> !status[CPS_B_WDX])
        else $error("expiry flag not cleared by time-out");
    chk_clear_flags: assert property (evt.wdt_clear |=> status[6:5] == 2'b11)
        else $error("flags wrong after watchdog clear");
    chk_por_status: assert property ($rose(rst_n) && !$past(por_n) |-> status == CPS_STATUS_POR)
        else $error("status wrong after power-on reset");
    chk_top_bit: assert property (status[7] == 1'b0)
        else $error("status bit 7 not zero");
    chk_direct_answer: assert property ($rose(avs_read) && avs_address[13:2] == CPS_PCLOW
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("direct read answer late");
    chk_mem_hold: assert property ((mem_req.rd || mem_req.wr) && !mem_ready |=> $stable(mem_req))
        else $error("memory request dropped early");
endmodule
bind cps_core_regs cps_core_regs_sva cps_core_regs_sva_inst (.clk(clk), .rst_n(rst_n),
    .por_n(por_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_waitrequest(avs_waitrequest), .alu(alu), .evt(evt), .status(status),
    .mem_req(mem_req), .mem_ready(mem_ready));

//--- verification/cps_core_regs_test.sv
`timescale 1ns/100ps
module cps_core_regs_test;
    import cps_pkg::*;
    logic clk, rst_n, por_n, avs_read, avs_write, avs_waitrequest, mem_ready, ld;
    logic [13:0] avs_address;
    logic [3:0] avs_byteenable, lat;
    logic [31:0] avs_writedata, avs_readdata;
    logic [21:0] call_pc, pc;
    logic [7:0] status, mem_rdata, ld_d;
    logic [11:0] ld_a;
    cps_alu_t alu;
    cps_evt_t evt;
    cps_mem_t mem_req;
    int fail_count, comparisons;
    cps_core_regs cps_core_regs_inst (.clk(clk), .rst_n(rst_n), .por_n(por_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .alu(alu), .evt(evt),
        .call_pc(call_pc), .work_reg(8'h00), .pc(pc), .status(status), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready));
    cps_mem_model cps_mem_model_inst (.clk(clk), .rst_n(rst_n), .req(mem_req),
        .rdata(mem_rdata), .ready(mem_ready), .lat(lat), .ld(ld), .ld_a(ld_a), .ld_d(ld_d));
    // Clock at 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [11:0] i, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {i, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 200);
        q = avs_readdata;
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            $display("ERROR bus_wait expected 0 seen %b", avs_waitrequest);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Let the accepted write settle before callers look at outputs
        @(negedge clk);
    endtask
    task wr(input logic [11:0] i, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, 4'hF, q);
    endtask
    task rd(input string n, input logic [11:0] i, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, i, 32'h0, 4'hF, q);
        chk(n, q, e);
    endtask
    task load(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        ld <= 1'b1;
        ld_a <= a;
        ld_d <= d;
        @(posedge clk);
        ld <= 1'b0;
    endtask
    task op(input cps_op_t o, input logic [7:0] a, b, s, m, e);
        @(posedge clk);
        alu <= '{o, a, b, s};
        @(posedge clk);
        alu.op <= CPS_OP_NONE;
        @(negedge clk);
        chk("flags", {24'h0, status & m}, {24'h0, e});
    endtask
    task pulse(input cps_evt_t v, input logic [7:0] e);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= '0;
        @(negedge clk);
        chk("status_top", {24'h0, status & 8'hE0}, {24'h0, e});
    endtask
    task t_reset_and_latch;
        rd("pc_low", CPS_PCLOW, 32'h0);
        rd("status", CPS_STATUS, 32'h60);
        rd("unmapped", 12'h000, CPS_UNMAPPED);
        wr(CPS_PCLATCH, 32'hFFFF);
        rd("latch", CPS_PCLATCH, 32'h1FFF);
        wr(CPS_PCLATCH, 32'h1234);
        wr(CPS_PCLOW, 32'h56);
        chk("pc", {10'h0, pc}, {10'h0, 5'h12, 1'b0, 16'h3456});
        wr(CPS_PCLATCH, 32'h0);
        rd("pc_low", CPS_PCLOW, 32'h56);
        rd("latch", CPS_PCLATCH, 32'h1234);
    endtask
    task t_stack;
        call_pc <= {5'h15, 1'b0, 16'h5CA3};
        pulse(5'b00001, 8'h60);
        rd("stack_pointer", CPS_STACK_POINTER, 32'h1);
        rd("stack_top", CPS_STKTOP, 32'h155CA3);
        pulse(5'b00010, 8'h60);
        chk("pc", {10'h0, pc}, {10'h0, 5'h15, 1'b0, 16'h5CA3});
        rd("stack_pointer", CPS_STACK_POINTER, 32'h0);
    endtask
    task t_flags;
        op(CPS_OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h1F, 8'h1A);
        op(CPS_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h1F, 8'h07);
        op(CPS_OP_SUB, 8'h35, 8'h35, 8'h00, 8'h1F, 8'h07);
        op(CPS_OP_RRC, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01);
        op(CPS_OP_RLC, 8'h00, 8'h00, 8'h7F, 8'h01, 8'h00);
        op(CPS_OP_RLC, 8'h00, 8'h00, 8'h80, 8'h01, 8'h01);
        wr(CPS_STATUS, 32'hFF);
        rd("status", CPS_STATUS, 32'h7F);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd("status", CPS_STATUS, 32'h7F);
        rd("pc_low", CPS_PCLOW, 32'h0);
    endtask
    task t_events;
        logic [31:0] q;
        pulse(5'b00100, 8'h20);
        pulse(5'b10000, 8'h60);
        pulse(5'b01000, 8'h40);
        pulse(5'b10000, 8'h60);
        wr(CPS_WSHADOW, 32'h99);
        bus(1'b1, CPS_WSHADOW, 32'h11, 4'h0, q);
        rd("shadow", CPS_WSHADOW, 32'h99);
    endtask
    // Plain, post-increment and post-decrement access through one pointer
    task t_ind(input logic [11:0] f, ind, inc, dec, b, input logic [3:0] l);
        lat <= l;
        load(b, 8'hA5);
        load(b + 12'h1, 8'h5A);
        wr(f, {20'h0, b});
        rd("indirect", ind, 32'hA5);
        rd("pointer", f, {20'h0, b});
        wr(inc, 32'h3C);
        rd("pointer", f, {20'h0, b + 12'h1});
        rd("post_dec", dec, 32'h5A);
        rd("pointer", f, {20'h0, b});
        rd("indirect", ind, 32'h3C);
    endtask
    task finish_test;
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test;
    end
    // Main sequence
    initial begin
        {rst_n, por_n, avs_read, avs_write, ld} = '0;
        {avs_address, avs_byteenable, avs_writedata, call_pc, lat, ld_a, ld_d} = '0;
        alu = '0;
        evt = '0;
        fail_count = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        t_reset_and_latch;
        t_stack;
        t_flags;
        t_events;
        t_ind(CPS_FSR0, CPS_IND0, CPS_INC0, CPS_DEC0, 12'h123, 4'h0);
        t_ind(CPS_FSR1, CPS_IND1, CPS_INC1, CPS_DEC1, 12'hFFF, 4'h2);
        t_ind(CPS_FSR2, CPS_IND2, CPS_INC2, CPS_DEC2, 12'h200, 4'h5);
        finish_test;
    end
endmodule
